/* File: rtl/acg_pkg.sv */
// Constants, types and register map for the record-path control block.
package acg_pkg;

   // Register offsets on the control port.
   localparam logic [7:0] ACG_OFS_AUX_CTRL   = 8'h51;
   localparam logic [7:0] ACG_OFS_CH1_VOLUME = 8'h52;
   localparam logic [7:0] ACG_OFS_CH1_TRIM   = 8'h53;
   localparam logic [7:0] ACG_OFS_CH1_PHASE  = 8'h54;

   // Reset values of the four registers.
   localparam logic [7:0] ACG_RST_AUX_CTRL   = 8'h00;
   localparam logic [7:0] ACG_RST_CH1_VOLUME = 8'ha1;
   localparam logic [7:0] ACG_RST_CH1_TRIM   = 8'h80;
   localparam logic [7:0] ACG_RST_CH1_PHASE  = 8'h00;

   // Field positions in the auxiliary converter control register.
   localparam int ACG_AUX_EN_BIT    = 7;
   localparam int ACG_AUX_MODE_HI   = 6;
   localparam int ACG_AUX_MODE_LO   = 5;
   localparam int ACG_AUX_START_BIT = 4;
   localparam int ACG_AUX_HALT_BIT  = 3;
   localparam int ACG_AUX_DONE_BIT  = 2;

   // Field positions in the trim and phase registers.
   localparam int ACG_TRIM_HI   = 7;
   localparam int ACG_TRIM_LO   = 4;
   localparam int ACG_PHASE_HI  = 7;
   localparam int ACG_PHASE_LO  = 2;
   localparam int ACG_PSEL_HI   = 1;
   localparam int ACG_PSEL_LO   = 0;

   // Volume code of unity gain, trim code of unity gain.
   localparam logic [7:0] ACG_VOL_UNITY  = 8'ha1;
   localparam logic [7:0] ACG_VOL_MUTE   = 8'h00;
   localparam logic [3:0] ACG_TRIM_UNITY = 4'h8;

   // Depth of the phase delay line in modulator clocks.
   localparam int ACG_PHASE_DEPTH = 64;

   // Auxiliary converter modes.
   typedef enum logic [1:0] {
      ACG_MODE_ONE_SINGLE = 2'h0,
      ACG_MODE_ONE_MULTI  = 2'h1,
      ACG_MODE_SEQ_SINGLE = 2'h2,
      ACG_MODE_SEQ_MULTI  = 2'h3
   } acg_mode_t;

   // Phase delay path select codes.
   typedef enum logic [1:0] {
      ACG_PATH_BOTH = 2'h0,
      ACG_PATH_ANA  = 2'h1,
      ACG_PATH_DIG  = 2'h2,
      ACG_PATH_RSVD = 2'h3
   } acg_path_t;

   // Controls handed to the auxiliary converter.
   typedef struct packed {
      logic       enable;      // Converter powered and allowed to run.
      acg_mode_t  mode;        // Selected conversion mode.
      logic       multi;       // Multi-channel scan when high.
      logic [1:0] channel;     // Single-ended selector for single modes.
      logic       start;       // One-cycle pulse starting a one-shot.
      logic       seq_run;     // Level, sequential conversions running.
   } acg_aux_t;

   // Gain settings for channel 1 in fixed steps.
   typedef struct packed {
      logic              mute;     // Digital output silenced.
      logic signed [8:0] vol_half; // Volume in 0.5 dB steps from 0 dB.
      logic signed [4:0] trim_dec; // Trim in 0.1 dB steps from 0 dB.
   } acg_gain_t;

endpackage : acg_pkg

/* File: rtl/acg_ctrl.sv */
// Record-path control registers, aux converter sequencer and phase delay.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Aux converter runs only while enable set.
// - Two-bit mode field picks four modes.
// - Single modes take channel from selector.
// - Writing start bit one starts one-shot.
// - Halt bit stops running sequential conversion.
// - Read-only done flag shows one-shot completion.
// - Volume code zero mutes channel output.
// - Code 1 -80 dB, 255 gives +47.
// - Code 161 unity; register resets there.
// - Trim spans -0.8 to +0.7 dB.
// - Phase field delays channel 0-63 clocks.
// - Path select applies delay analog/digital.
// - Source codes 2,3 pick single-ended input.
module acg_ctrl
   import acg_pkg::*;
#(
   parameter int PHASE_DEPTH = ACG_PHASE_DEPTH  // Delay line length.
) (
   input  wire logic       i_ref_clk,       // 100 MHz device clock.
   input  wire logic       i_rstn,          // Synchronous reset, low.
   input  wire logic       i_wr_en,         // Register write strobe.
   input  wire logic       i_rd_en,         // Register read strobe.
   input  wire logic [7:0] i_addr,          // Register offset.
   input  wire logic [7:0] i_wdata,         // Write data.
   output logic      [7:0] o_rdata,         // Read data, one cycle late.
   input  wire logic [1:0] i_ch1_input_source_sel, // Channel source code.
   input  wire logic       i_conv_done,     // Converter finished a one-shot.
   input  wire logic       i_mod_tick,      // One pulse per modulator clock.
   input  wire logic       i_mod_bit,       // Modulator output bit.
   output acg_aux_t        o_aux,           // Converter controls.
   output acg_gain_t       o_gain,          // Channel 1 gain settings.
   output logic      [5:0] o_ana_delay,     // Delay for analog section.
   output logic            o_dig_bit        // Delayed digital stream bit.
);

   // Sequencer states of the auxiliary converter.
   // OFF is held while the enable bit is clear; IDLE waits for a start
   // or a sequential mode; SHOT and SEQ are the two running states.
   typedef enum logic [1:0] {
      ACG_ST_OFF,
      ACG_ST_IDLE,
      ACG_ST_SHOT,
      ACG_ST_SEQ
   } acg_state_t;

   // Register fields are held one by one rather than as whole bytes, so
   // reserved and write-only positions have no storage at all.
   logic              aux_en_r;         // Converter enable bit.
   acg_mode_t         aux_mode_r;       // Converter mode field.
   logic              aux_halt_r;       // Sequential halt bit.
   logic              done_r;           // One-shot done status.
   logic [7:0]        vol_r;            // Channel 1 volume code.
   logic [3:0]        trim_r;           // Channel 1 trim code.
   logic [5:0]        phase_r;          // Phase delay in modulator clocks.
   acg_path_t         path_r;           // Phase delay path select.
   acg_state_t        state_r;          // Sequencer state.
   acg_state_t        state_nxt;        // Next sequencer state.
   logic [PHASE_DEPTH-1:0] line_r;      // Modulator bit delay line.
   logic              wr_aux;           // Write to the aux register.
   logic              start_req;        // Accepted one-shot request.
   logic              is_single;        // Mode is a single-channel one.
   logic              is_seq;           // Mode is a sequential one.
   logic [7:0]        rd_nxt;           // Read mux result.

   // Decode of the aux register write and mode class. Only the top mode
   // bit separates one-shot from sequential, and only the low bit
   // separates single from multi channel scans.
   assign wr_aux    = i_wr_en && (i_addr == ACG_OFS_AUX_CTRL);
   assign is_single = (aux_mode_r == ACG_MODE_ONE_SINGLE) ||
                      (aux_mode_r == ACG_MODE_SEQ_SINGLE);
   assign is_seq    = aux_mode_r[1];
   // The start bit is never stored, so a write of one is the trigger.
   // A start in a sequential mode is dropped, as is one written while the
   // converter was still disabled.
   assign start_req = wr_aux && i_wdata[ACG_AUX_START_BIT]
                      && aux_en_r && !is_seq;

   // Aux control fields. Reserved bits are dropped; software keeps them
   // zero, and they read back as zero whatever was written.
   // The done bit in the written byte is ignored as it is read-only.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         aux_en_r   <= ACG_RST_AUX_CTRL[ACG_AUX_EN_BIT];
         aux_mode_r <= ACG_MODE_ONE_SINGLE;
         aux_halt_r <= ACG_RST_AUX_CTRL[ACG_AUX_HALT_BIT];
      end else if (wr_aux) begin
         aux_en_r   <= i_wdata[ACG_AUX_EN_BIT];
         aux_mode_r <= acg_mode_t'(
                       i_wdata[ACG_AUX_MODE_HI:ACG_AUX_MODE_LO]);
         aux_halt_r <= i_wdata[ACG_AUX_HALT_BIT];
      end
   end

   // Done flag. A completion in the same cycle as a new start wins, so
   // an event is never lost under the clear.
   // The flag only listens while a one-shot is in flight, so a stray
   // completion during a sequential run leaves it untouched.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         done_r <= ACG_RST_AUX_CTRL[ACG_AUX_DONE_BIT];
      end else if (state_r == ACG_ST_SHOT && i_conv_done) begin
         done_r <= 1'b1;
      end else if (start_req) begin
         done_r <= 1'b0;
      end
   end

   // Channel 1 gain and phase registers. Writes to offsets outside the
   // block fall through the case untouched. The reserved path code is
   // stored as written and handled at the delay routing instead, so a
   // read shows what software wrote.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         vol_r   <= ACG_RST_CH1_VOLUME;
         trim_r  <= ACG_RST_CH1_TRIM[ACG_TRIM_HI:ACG_TRIM_LO];
         phase_r <= ACG_RST_CH1_PHASE[ACG_PHASE_HI:ACG_PHASE_LO];
         path_r  <= ACG_PATH_BOTH;
      end else if (i_wr_en) begin
         case (i_addr)
            ACG_OFS_CH1_VOLUME: begin
               vol_r <= i_wdata;
            end
            ACG_OFS_CH1_TRIM: begin
               trim_r <= i_wdata[ACG_TRIM_HI:ACG_TRIM_LO];
            end
            ACG_OFS_CH1_PHASE: begin
               phase_r <= i_wdata[ACG_PHASE_HI:ACG_PHASE_LO];
               path_r  <= acg_path_t'(i_wdata[ACG_PSEL_HI:ACG_PSEL_LO]);
            end
            default: begin
               // Other offsets belong elsewhere; nothing to store.
            end
         endcase
      end
   end

   // Next-state logic of the converter sequencer. The enable check sits
   // last so that it overrides every branch above it; a disable can
   // never be lost behind a pending conversion.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ACG_ST_OFF: begin
            // A start written right behind the enable is still taken.
            if (start_req) begin
               state_nxt = ACG_ST_SHOT;
            end else if (aux_en_r) begin
               state_nxt = ACG_ST_IDLE;
            end
         end
         ACG_ST_IDLE: begin
            if (start_req) begin
               state_nxt = ACG_ST_SHOT;
            end else if (is_seq && !aux_halt_r) begin
               state_nxt = ACG_ST_SEQ;
            end
         end
         ACG_ST_SHOT: begin
            if (i_conv_done) begin
               state_nxt = ACG_ST_IDLE;
            end
         end
         ACG_ST_SEQ: begin
            // Halting or a mode change back to one-shot ends the run.
            if (aux_halt_r || !is_seq) begin
               state_nxt = ACG_ST_IDLE;
            end
         end
         default: begin
            state_nxt = ACG_ST_OFF;
         end
      endcase
      // Clearing the enable aborts whatever is running.
      if (!aux_en_r) begin
         state_nxt = ACG_ST_OFF;
      end
   end

   // Sequencer state register.
   // Reset parks it in the off state, matching the cleared enable bit.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         state_r <= ACG_ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Converter controls, all registered so the outputs are glitch free.
   // Each field but seq_run lags its source by one clock; seq_run is taken from state_nxt and so
   // tracks state_r. The converter side sees a consistent set since all of them move on the same edge.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_aux <= '0;
      end else begin
         o_aux.enable  <= aux_en_r;
         o_aux.mode    <= aux_mode_r;
         o_aux.multi   <= !is_single;
         // Only the single-ended mux codes name an input pin; other
         // codes leave the low bit, which is then a don't-care.
         o_aux.channel <= is_single ? i_ch1_input_source_sel
                                    : 2'h0;
         o_aux.start   <= start_req;
         o_aux.seq_run <= (state_nxt == ACG_ST_SEQ);
      end
   end

   // Gain settings: signed step counts from the unity codes.
   // Keeping the counts signed lets the gain stage treat cut and boost
   // with one multiplier.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_gain <= '0;
      end else begin
         o_gain.mute     <= (vol_r == ACG_VOL_MUTE);
         // Code 1 maps to -160 half steps, i.e. -80 dB; code 255 to +94.
         o_gain.vol_half <= $signed({1'b0, vol_r})
                            - $signed({1'b0, ACG_VOL_UNITY});
         o_gain.trim_dec <= $signed({1'b0, trim_r})
                            - $signed({1'b0, ACG_TRIM_UNITY});
      end
   end

   // Modulator delay line. It moves only on modulator ticks, so the
   // delay is counted in modulator clocks and not in device clocks.
   // Ticks that come faster than one per clock cannot be seen; the
   // modulator clock must not exceed the device clock.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         line_r <= '0;
      end else if (i_mod_tick) begin
         line_r <= {line_r[PHASE_DEPTH-2:0], i_mod_bit};
      end
   end

   // Delay routing. Code 0 takes the live input bit, so it adds no delay; code n reads tap n-1.
   // The reserved path code is treated as no delay anywhere.
   // The output flop adds one device clock on top of the modulator delay,
   // the same for every code, so the relative phase is kept.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_dig_bit   <= 1'b0;
         o_ana_delay <= 6'h00;
      end else begin
         if ((path_r == ACG_PATH_BOTH || path_r == ACG_PATH_DIG)
             && phase_r != 6'h00) begin
            o_dig_bit <= line_r[phase_r - 6'h01];
         end else begin
            o_dig_bit <= i_mod_bit;
         end
         if (path_r == ACG_PATH_BOTH || path_r == ACG_PATH_ANA) begin
            o_ana_delay <= phase_r;
         end else begin
            o_ana_delay <= 6'h00;
         end
      end
   end

   // Read mux. The start bit always reads zero since it never latches.
   // Unmapped offsets read zero, so probing the map is harmless.
   always_comb begin
      case (i_addr)
         ACG_OFS_AUX_CTRL: begin
            rd_nxt = {aux_en_r, aux_mode_r, 1'b0, aux_halt_r,
                      done_r, 2'h0};
         end
         ACG_OFS_CH1_VOLUME: begin
            rd_nxt = vol_r;
         end
         ACG_OFS_CH1_TRIM: begin
            rd_nxt = {trim_r, 4'h0};
         end
         ACG_OFS_CH1_PHASE: begin
            rd_nxt = {phase_r, path_r};
         end
         default: begin
            rd_nxt = 8'h00;
         end
      endcase
   end

   // Registered read data, updated only on a read strobe.
   // Holding the last value between reads spares the port needless
   // toggling while it is idle.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_rd_en) begin
         o_rdata <= rd_nxt;
      end
   end

endmodule : acg_ctrl

`default_nettype wire

/* File: dv/acg_ctrl_checker.sv */
// Port assertions for the record-path control block.
`timescale 1ns/1ps
`default_nettype none
module acg_ctrl_checker
   import acg_pkg::*;
#(
   parameter int PHASE_DEPTH = 64  // Delay line length.
) (
   input wire logic       i_ref_clk,  // Clock.
   input wire logic       i_rstn,     // Reset, low.
   input wire logic       i_wr_en,    // Write strobe.
   input wire logic       i_rd_en,    // Read strobe.
   input wire logic [7:0] i_addr,     // Offset.
   input wire logic [7:0] i_wdata,    // Write data.
   input wire logic [7:0] o_rdata,    // Read data.
   input wire logic [1:0] i_ch1_input_source_sel, // Source code.
   input wire logic       i_conv_done, // Conversion done.
   input wire logic       i_mod_tick, // Modulator tick.
   input wire logic       i_mod_bit,  // Modulator bit.
   input wire acg_aux_t   o_aux,      // Converter controls.
   input wire acg_gain_t  o_gain,     // Gain settings.
   input wire logic [5:0] o_ana_delay, // Analog delay.
   input wire logic       o_dig_bit   // Delayed bit.
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // Decoded writes, so each property reads short.
   wire logic       w51 = i_wr_en && i_addr == 8'h51;
   wire logic       w52 = i_wr_en && i_addr == 8'h52;
   wire logic [3:0] trim_in = i_wdata[7:4];
   // Digital-only and reserved path codes leave the analog side undelayed.
   wire logic [5:0] ana_exp = i_wdata[1] ? 6'h00 : i_wdata[7:2];
   property p_en_clear;
      w51 && !i_wdata[7] |-> ##[1:2] !o_aux.seq_run;
   endproperty
   a_en_clear: assert property (p_en_clear)
      else $error("sequencer ran on after disable");
   property p_halt;
      w51 && i_wdata[3] |-> ##[1:2] !o_aux.seq_run;
   endproperty
   a_halt: assert property (p_halt)
      else $error("sequencer ran on after halt");
   property p_start_mode;
      o_aux.start |-> o_aux.enable && !o_aux.mode[1];
   endproperty
   a_start_mode: assert property (p_start_mode)
      else $error("start pulse outside enabled one-shot");
   property p_start_taken;
      w51 && i_wdata[7] && i_wdata[4] && !i_wdata[6] && o_aux.enable
         |=> o_aux.start;
   endproperty
   a_start_taken: assert property (p_start_taken)
      else $error("start write gave no pulse");
   property p_start_pulse;
      o_aux.start |=> !o_aux.start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("start held longer than one cycle");
   property p_multi;
      o_aux.mode[0] |-> o_aux.multi && o_aux.channel == 2'h0;
   endproperty
   a_multi: assert property (p_multi)
      else $error("multi mode shows a channel");
   property p_mute;
      w52 && i_wdata == 8'h00 |-> ##2 o_gain.mute;
   endproperty
   a_mute: assert property (p_mute)
      else $error("code zero did not mute");
   property p_vol;
      w52 && i_wdata != 8'h00 |-> ##2 !o_gain.mute &&
         o_gain.vol_half == ({1'b0, $past(i_wdata, 2)} - 9'h0a1);
   endproperty
   a_vol: assert property (p_vol)
      else $error("volume step wrong");
   property p_trim;
      i_wr_en && i_addr == 8'h53 |-> ##2
         o_gain.trim_dec == ({1'b0, $past(trim_in, 2)} - 5'h08);
   endproperty
   a_trim: assert property (p_trim)
      else $error("trim step wrong");
   property p_phase;
      i_wr_en && i_addr == 8'h54 |-> ##2 o_ana_delay == $past(ana_exp, 2);
   endproperty
   a_phase: assert property (p_phase)
      else $error("analog delay wrong");
   property p_rsvd;
      i_rd_en && i_addr == 8'h51 |=> o_rdata[4] == 1'b0 &&
         o_rdata[1:0] == 2'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("write-only or reserved bits read nonzero");
endmodule : acg_ctrl_checker
bind acg_ctrl acg_ctrl_checker #(.PHASE_DEPTH(PHASE_DEPTH)) i_chk (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wr_en(i_wr_en),
   .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
   .o_rdata(o_rdata), .i_ch1_input_source_sel(i_ch1_input_source_sel),
   .i_conv_done(i_conv_done), .i_mod_tick(i_mod_tick),
   .i_mod_bit(i_mod_bit), .o_aux(o_aux), .o_gain(o_gain),
   .o_ana_delay(o_ana_delay), .o_dig_bit(o_dig_bit));
`default_nettype wire

/* File: dv/acg_ctrl_tb.sv */
// Self-checking bench for the record-path control block.
`timescale 1ns/1ps
`default_nettype none
module acg_ctrl_tb;
   import acg_pkg::*;
   logic       clk, rstn, wr_en, rd_en, done, mtick, mbit, dig;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] src;
   logic [5:0] ana;
   acg_aux_t   aux;
   acg_gain_t  gain;
   logic       hist [0:255];   // Bits fed to the delay line.
   int         fail_count = 0; // Mismatches seen.
   int         n_compared = 0; // Comparisons made.
   acg_ctrl i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .i_ch1_input_source_sel(src), .i_conv_done(done),
      .i_mod_tick(mtick), .i_mod_bit(mbit), .o_aux(aux), .o_gain(gain),
      .o_ana_delay(ana), .o_dig_bit(dig));
   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts every comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Steps past n edges; inputs then move 1 ns later, clear of sampling.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // One-cycle write strobe.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      tick(1);
      wr_en = 1'b0;
   endtask : wr
   // One-cycle read; data is valid in the cycle after the strobe edge.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      tick(1);
      rd_en = 1'b1;
      addr = a;
      tick(1);
      rd_en = 1'b0;
      chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask : rd
   // Reset values and outputs, then access kinds and a hole in the map.
   task automatic t_regs();
      chk("outputs", 16'h0000, {aux, ana, dig});
      chk("gain", 16'h0000, {1'b0, gain});
      rd(8'h51, 8'h00);
      rd(8'h52, 8'ha1);
      rd(8'h53, 8'h80);
      rd(8'h54, 8'h00);
      wr(8'h51, 8'h7f);
      rd(8'h51, 8'h68);
      wr(8'h51, 8'h00);
      wr(8'h53, 8'hff);
      rd(8'h53, 8'hf0);
      wr(8'h60, 8'hff);
      rd(8'h60, 8'h00);
   endtask : t_regs
   // Volume end points, unity and mute, then every trim code.
   task automatic t_gain();
      logic [7:0] v [7] = '{8'h01, 8'h02, 8'ha1, 8'ha2, 8'hfe, 8'hff, 8'h00};
      // Half-dB steps from unity: -80, -79.5, 0, +0.5, +46.5 and +47 dB.
      logic [8:0] e [7] = '{9'h160, 9'h161, 9'h000, 9'h001, 9'h05d,
                            9'h05e, 9'h000};
      for (int i = 0; i < 7; i++) begin
         wr(8'h52, v[i]);
         tick(1);
         if (v[i] == 8'h00)
            chk("mute", 16'h0001, {15'h0, gain.mute});
         else
            chk("vol", {7'h0, e[i]},
                {6'h0, gain.mute, gain.vol_half});
      end
      for (int c = 0; c < 16; c++) begin
         wr(8'h53, {4'(c), 4'h0});
         tick(1);
         chk("trim", {11'h0, 5'(c - 8)}, {11'h0, gain.trim_dec});
      end
   endtask : t_gain
   // Runs the delay line with a tick every s cycles and checks the tap
   // just after each tick from the 70th on; the bit is inverted between ticks, so a line
   // that shifted off the tick would be caught.
   task automatic t_dig(input logic [5:0] ph, input logic [1:0] ps,
                        input int d, input int s);
      wr(8'h54, {ph, ps});
      tick(1);
      chk("ana", {10'h0, (ps[1] ? 6'h00 : ph)}, {10'h0, ana});
      for (int k = 0; k < 140; k++) begin
         hist[k] = k[0] ^ k[2] ^ k[5];
         mtick = 1'b1;
         mbit = hist[k];
         tick(1);
         if (k >= 70)
            chk("dig", {15'h0, hist[k - d]}, {15'h0, dig});
         if (s > 1) begin
            mtick = 1'b0;
            mbit = ~hist[k];
            tick(s - 1);
         end
      end
      mtick = 1'b0;
   endtask : t_dig
   // One-shot start, done flag, multi scan and a start while disabled.
   task automatic t_shot();
      src = 2'h2;
      wr(8'h51, 8'h80);
      tick(2);
      chk("aux", 16'h0088, {8'h00, aux});
      wr(8'h51, 8'h90);
      chk("start", 16'h0001, {15'h0, aux.start});
      tick(1);
      chk("start", 16'h0000, {15'h0, aux.start});
      rd(8'h51, 8'h80);
      done = 1'b1;
      tick(1);
      done = 1'b0;
      rd(8'h51, 8'h84);
      wr(8'h51, 8'h90);
      rd(8'h51, 8'h80);
      wr(8'h51, 8'ha0);
      tick(2);
      chk("aux", 16'h00b0, {8'h00, aux});
      wr(8'h51, 8'hb0);
      chk("start", 16'h0001, {15'h0, aux.start});
      wr(8'h51, 8'h00);
      tick(2);
      wr(8'h51, 8'h10);
      chk("start", 16'h0000, {15'h0, aux.start});
   endtask : t_shot
   // Sequential modes: run, refuse start, halt, restart, disable.
   task automatic t_seq();
      wr(8'h51, 8'hc0);
      tick(4);
      chk("aux", 16'h00c9, {8'h00, aux});
      wr(8'h51, 8'hd0);
      chk("start", 16'h0000, {15'h0, aux.start});
      wr(8'h51, 8'hc8);
      tick(2);
      chk("run", 16'h0000, {15'h0, aux.seq_run});
      wr(8'h51, 8'he0);
      tick(4);
      chk("aux", 16'h00f1, {8'h00, aux});
      wr(8'h51, 8'h60);
      tick(2);
      chk("run", 16'h0000, {15'h0, aux.seq_run});
   endtask : t_seq
   // Prints the verdict and ends the run.
   task automatic close_out();
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   // Main sequence; reset spans 12 cycles.
   initial begin
      {rstn, wr_en, rd_en, done, mtick, mbit, addr, wdata, src} = '0;
      tick(12);
      rstn = 1'b1;
      t_regs();
      t_gain();
      t_dig(6'h3f, 2'h0, 63, 1);
      t_dig(6'h05, 2'h2, 5, 2);
      t_dig(6'h3f, 2'h1, 0, 1);
      t_dig(6'h3f, 2'h3, 0, 1);
      t_dig(6'h01, 2'h0, 1, 2);
      t_shot();
      t_seq();
      close_out();
   end
   // The run needs about 1150 cycles; close to nine times that means a hang.
   initial begin
      #100us;
      fail_count++;
      close_out();
   end
endmodule : acg_ctrl_tb
`default_nettype wire
